// ==== hw/fsrx_corr.v ====
/*
 * Soft correlator over 16 frequency estimates against one 16-bit word.
 * Assumes the window holds estimate n in bits 4n+3..4n, n = 0 oldest.
 */
`timescale 1ns/10ps
`default_nettype none

module fsrx_corr (
	input  wire        i_clk,
	input  wire        i_rst_b,
	input  wire [63:0] i_win,
	input  wire [15:0] i_word,
	output reg  [7:0]  o_sum
);

	// Running sum chain; estimates within +-7 give at most +-112, which fits 8 bits signed
	wire [135:0] acc;
	assign acc[7:0] = 8'h00;

	genvar n;
	generate
		for (n = 0; n < 16; n = n + 1) begin : g_tap
			wire [7:0] x = {{4{i_win[4*n+3]}}, i_win[4*n+3:4*n]};
			// Word bit 15 pairs with the oldest estimate
			wire [7:0] t = i_word[15-n] ? x : (8'h00 - x);
			assign acc[8*n+15:8*n+8] = acc[8*n+7:8*n] + t;
		end
	endgenerate

	always @(posedge i_clk) begin
		if (!i_rst_b)
			o_sum <= 8'h00;
		else
			o_sum <= acc[135:128];
	end

endmodule

`default_nettype wire

// ==== hw/fsrx_map.vh ====
/*
 * Register offsets, field positions and reset values of the FSK receive
 * frame acquisition block. Assumes an 8-bit register port.
 */
`ifndef FSRX_MAP_VH
`define FSRX_MAP_VH

// ==========================================================
// Register offsets
`define FSRX_A_CFG      8'h00
`define FSRX_A_PTHR     8'h01
`define FSRX_A_STHR     8'h02
`define FSRX_A_SCFG     8'h03
`define FSRX_A_PLEN_LO  8'h04
`define FSRX_A_PLEN_HI  8'h05
`define FSRX_A_SW0_LO   8'h06
`define FSRX_A_SW0_HI   8'h07
`define FSRX_A_SW1_LO   8'h08
`define FSRX_A_SW1_HI   8'h09
`define FSRX_A_RAW_LO   8'h0A
`define FSRX_A_RAW_HI   8'h0B
`define FSRX_A_FREEZE   8'h10
`define FSRX_A_PHR      8'h11
`define FSRX_A_RXL_LO   8'h12
`define FSRX_A_RXL_HI   8'h13
`define FSRX_A_EDV      8'h14

// ==========================================================
// Field positions in the configuration register
`define FSRX_B_PTO      0
`define FSRX_B_MSE      1
`define FSRX_B_SS       2
`define FSRX_B_HQ       3
`define FSRX_B_REV      4
`define FSRX_B_PDTM     5
`define FSRX_B_EN       6

// ==========================================================
// Reset values
`define FSRX_R_CFG      8'h40
`define FSRX_R_PTHR     8'h40
`define FSRX_R_STHR     4'h8
`define FSRX_R_SCFG     4'h0
`define FSRX_R_PLEN     10'h008
`define FSRX_R_SW0      16'h904E
`define FSRX_R_SW1      16'h7A0E
`define FSRX_R_RAW      11'h000
`define FSRX_PN_SEED    9'h1FF
`define FSRX_PHR_LAST   4'hF

`endif

// ==== hw/fsrx_top.v ====
/*
 * FSK receive frame acquisition: preamble lock, sync word search, header
 * parse, mode-switch and RAW delivery into the frame buffer.
 * Assumes a demodulator giving soft estimates and a preamble correlator
 * value per symbol, and a decoder giving info bits after sync.
 */
//
// Contract
// - Searching for preamble: listen state, freeze status reads 0.
// - Correlator value above preamble threshold enters lock, freeze reads 1.
// - Timeout enabled: leave lock when no sync within preamble length.
// - Timeout disabled: leave lock once correlation drops to threshold.
// - Sync word search runs only in preamble lock.
// - Dual sense tests both word hypotheses at once against threshold.
// - Dual sense prefers config 0 and flag 0; config 1 only alone.
// - Single sense needs word 0 then word 1; config 0, flag 0.
// - Winning config selects RAW and FEC for the whole frame.
// - Threshold 15 with hard quantizing accepts only exact words.
// - Non-RAW, non-switch header: parse FCS type, de-whiten, length.
// - Expose length, switch flag, reserved bits, FCS, DW, sync flag, power.
// - Zero-length frames are dropped silently with no frame start.
// - Mode-switch header: write 16 bits raw to buffer, set flag.
// - Mode-switch frame disables FCS and address filtering.
// - RAW: write octets with chosen bit order, no de-whiten or filters.
// - Coded RAW frames buffer decoded bits; length counts decoded octets.
// - Sync threshold equals seven times the threshold field.
// - Single sense correlates word 0 then next 16 with word 1.
// - Hard quantizing maps estimates to -7 if negative, else +7.
`include "fsrx_map.vh"
`timescale 1ns/10ps
`default_nettype none

module fsrx_top (
	input  wire        i_clk,
	input  wire        i_rst_b,
	input  wire [7:0]  i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [7:0]  o_rdata,
	input  wire        i_sym_vld,
	input  wire [3:0]  i_sym,
	input  wire [7:0]  i_pre_corr,
	input  wire        i_dbit_vld,
	input  wire        i_dbit,
	input  wire [7:0]  i_energy,
	output reg         o_freeze_status,
	output reg         o_raw_mode,
	output reg         o_fec_en,
	output reg         o_fcs_dis,
	output reg         o_addr_filt_dis,
	output reg         o_frame_start_irq,
	output reg         o_rx_done,
	output reg         o_fb_we,
	output reg  [10:0] o_fb_addr,
	output reg  [7:0]  o_fb_wdata
);

	localparam [3:0] ST_LISTEN = 4'b0001;
	localparam [3:0] ST_LOCK   = 4'b0010;
	localparam [3:0] ST_PHR    = 4'b0100;
	localparam [3:0] ST_PSDU   = 4'b1000;

	// ==========================================================
	// Register file
	reg  [7:0]   cfg_r;
	reg  [7:0]   pthr_r;
	reg  [3:0]   sthr_r;
	reg  [3:0]   scfg_r;
	reg  [9:0]   plen_r;
	reg  [15:0]  sw0_r;
	reg  [15:0]  sw1_r;
	reg  [10:0]  rlen_r;
	reg  [5:0]   phr_st_r;
	reg  [10:0]  rxlen_r;
	reg  [7:0]   edv_r;
	reg  [7:0]   rd_nxt;

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			cfg_r  <= `FSRX_R_CFG;
			pthr_r <= `FSRX_R_PTHR;
			sthr_r <= `FSRX_R_STHR;
			scfg_r <= `FSRX_R_SCFG;
			plen_r <= `FSRX_R_PLEN;
			sw0_r  <= `FSRX_R_SW0;
			sw1_r  <= `FSRX_R_SW1;
			rlen_r <= `FSRX_R_RAW;
		end else if (i_wr) begin
			case (i_addr)
				`FSRX_A_CFG:     cfg_r <= i_wdata;
				`FSRX_A_PTHR:    pthr_r <= i_wdata;
				`FSRX_A_STHR:    sthr_r <= i_wdata[3:0];
				`FSRX_A_SCFG:    scfg_r <= i_wdata[3:0];
				`FSRX_A_PLEN_LO: plen_r[7:0] <= i_wdata;
				`FSRX_A_PLEN_HI: plen_r[9:8] <= i_wdata[1:0];
				`FSRX_A_SW0_LO:  sw0_r[7:0] <= i_wdata;
				`FSRX_A_SW0_HI:  sw0_r[15:8] <= i_wdata;
				`FSRX_A_SW1_LO:  sw1_r[7:0] <= i_wdata;
				`FSRX_A_SW1_HI:  sw1_r[15:8] <= i_wdata;
				`FSRX_A_RAW_LO:  rlen_r[7:0] <= i_wdata;
				`FSRX_A_RAW_HI:  rlen_r[10:8] <= i_wdata[2:0];
				default:         cfg_r <= cfg_r;
			endcase
		end
	end

	reg  [3:0]   state_r;

	always @* begin
		rd_nxt = 8'h00;
		case (i_addr)
			`FSRX_A_CFG:     rd_nxt = cfg_r;
			`FSRX_A_PTHR:    rd_nxt = pthr_r;
			`FSRX_A_STHR:    rd_nxt = {4'h0, sthr_r};
			`FSRX_A_SCFG:    rd_nxt = {4'h0, scfg_r};
			`FSRX_A_PLEN_LO: rd_nxt = plen_r[7:0];
			`FSRX_A_PLEN_HI: rd_nxt = {6'h00, plen_r[9:8]};
			`FSRX_A_SW0_LO:  rd_nxt = sw0_r[7:0];
			`FSRX_A_SW0_HI:  rd_nxt = sw0_r[15:8];
			`FSRX_A_SW1_LO:  rd_nxt = sw1_r[7:0];
			`FSRX_A_SW1_HI:  rd_nxt = sw1_r[15:8];
			`FSRX_A_RAW_LO:  rd_nxt = rlen_r[7:0];
			`FSRX_A_RAW_HI:  rd_nxt = {5'h00, rlen_r[10:8]};
			`FSRX_A_FREEZE:  rd_nxt = {7'h00, ~state_r[0]};
			`FSRX_A_PHR:     rd_nxt = {2'h0, phr_st_r};
			`FSRX_A_RXL_LO:  rd_nxt = rxlen_r[7:0];
			`FSRX_A_RXL_HI:  rd_nxt = {5'h00, rxlen_r[10:8]};
			`FSRX_A_EDV:     rd_nxt = edv_r;
			default:         rd_nxt = 8'h00;
		endcase
	end

	always @(posedge i_clk) begin
		if (!i_rst_b)
			o_rdata <= 8'h00;
		else
			o_rdata <= i_rd ? rd_nxt : 8'h00;
	end

	// ==========================================================
	// Symbol history and correlators
	wire         hq  = cfg_r[`FSRX_B_HQ];
	wire         ss  = cfg_r[`FSRX_B_SS];
	wire         pto = cfg_r[`FSRX_B_PTO];
	wire         mse = cfg_r[`FSRX_B_MSE];
	wire         rev = cfg_r[`FSRX_B_REV];
	wire         en  = cfg_r[`FSRX_B_EN];
	// -7 or +7 only, so full confidence on every bit decision
	wire [3:0]   qsym = hq ? (i_sym[3] ? 4'h9 : 4'h7) : i_sym;
	reg  [127:0] hist_r;
	reg  [1:0]   v_d_r;
	wire [23:0]  csum;

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			hist_r <= 128'h0;
			v_d_r  <= 2'b00;
		end else begin
			// Registered sums see a symbol two edges after it is taken
			v_d_r <= {v_d_r[0], i_sym_vld};
			if (i_sym_vld)
				hist_r <= {hist_r[123:0], qsym};
		end
	end

	// Window slot order is reversed so that slot n is estimate k+n
	wire [63:0]  win_new;
	wire [63:0]  win_old;
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_win
			assign win_new[4*g+3:4*g] = hist_r[4*(15-g)+3:4*(15-g)];
			assign win_old[4*g+3:4*g] = hist_r[4*(31-g)+3:4*(31-g)];
		end
	endgenerate

	// Slot 2 holds word 0 against the older 16 estimates for single sense
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_corr
			fsrx_corr u_corr (
				.i_clk   (i_clk),
				.i_rst_b (i_rst_b),
				.i_win   ((g == 2) ? win_old : win_new),
				.i_word  ((g == 1) ? sw1_r : sw0_r),
				.o_sum   (csum[8*g+7:8*g])
			);
		end
	endgenerate
	wire [7:0]   s0 = csum[7:0];
	wire [7:0]   s1 = csum[15:8];
	wire [7:0]   s2 = csum[23:16];

	wire [7:0]   tsfd = {1'b0, sthr_r, 3'b000} - {4'h0, sthr_r};
	wire         h0 = $signed(s0) > $signed(tsfd);
	wire         h1 = $signed(s1) > $signed(tsfd);
	wire         hs = ($signed(s2) > $signed(tsfd)) & h1;
	wire         hit = ss ? hs : (h0 | h1);
	wire         sel1 = ~ss & ~h0 & h1;
	wire [1:0]   win_cfg = sel1 ? scfg_r[3:2] : scfg_r[1:0];

	// ==========================================================
	// Frame sequencer
	reg  [12:0]  tcnt_r;
	reg  [3:0]   pcnt_r;
	reg  [15:0]  phr_r;
	reg          ms_r;
	reg          dw_r;
	reg          rev_r;
	reg  [8:0]   pn_r;
	reg  [13:0]  bcnt_r;
	reg  [7:0]   oct_r;
	reg  [2:0]   ocnt_r;
	reg  [10:0]  fba_r;

	wire [12:0]  tlim = {plen_r, 3'b000};
	wire         ms_now = (pcnt_r == 4'h0) ? (i_dbit & mse) : ms_r;
	wire [15:0]  phr_full = {phr_r[14:0], i_dbit};
	wire [10:0]  phr_len = phr_full[10:0];
	wire         in_phr = state_r[2] & i_dbit_vld;
	wire         in_psdu = state_r[3] & i_dbit_vld;
	wire         push = (in_phr & ms_now) | in_psdu;
	wire         pbit = (state_r[3] & dw_r) ? (i_dbit ^ pn_r[0]) : i_dbit;
	wire [7:0]   oct_nxt = rev_r ? {oct_r[6:0], pbit} : {pbit, oct_r[7:1]};

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_r <= ST_LISTEN;
			tcnt_r <= 13'h0000;
			pcnt_r <= 4'h0;
			phr_r <= 16'h0000;
			ms_r <= 1'b0;
			dw_r <= 1'b0;
			rev_r <= 1'b0;
			pn_r <= `FSRX_PN_SEED;
			bcnt_r <= 14'h0000;
			oct_r <= 8'h00;
			ocnt_r <= 3'h0;
			fba_r <= 11'h000;
			phr_st_r <= 6'h00;
			rxlen_r <= 11'h000;
			edv_r <= 8'h00;
			o_raw_mode <= 1'b0;
			o_fec_en <= 1'b0;
			o_fcs_dis <= 1'b0;
			o_addr_filt_dis <= 1'b0;
			o_frame_start_irq <= 1'b0;
			o_rx_done <= 1'b0;
			o_fb_we <= 1'b0;
			o_fb_addr <= 11'h000;
			o_fb_wdata <= 8'h00;
			o_freeze_status <= 1'b0;
		end else begin
			o_frame_start_irq <= 1'b0;
			o_rx_done <= 1'b0;
			o_fb_we <= 1'b0;
			// Trails the state by one cycle so it stays a plain flip-flop
			o_freeze_status <= ~state_r[0];
			if (push) begin
				oct_r <= oct_nxt;
				ocnt_r <= ocnt_r + 3'h1;
				if (ocnt_r == 3'h7) begin
					o_fb_we <= 1'b1;
					o_fb_wdata <= oct_nxt;
					o_fb_addr <= fba_r;
					fba_r <= fba_r + 11'h001;
				end
			end
			case (state_r)
				ST_LISTEN: begin
					tcnt_r <= 13'h0000;
					if (en & i_sym_vld & (i_pre_corr > pthr_r))
						state_r <= ST_LOCK;
				end
				ST_LOCK: begin
					if (v_d_r[1] & hit) begin
						o_raw_mode <= win_cfg[0];
						o_fec_en <= win_cfg[1];
						phr_st_r <= {sel1, 5'h00};
						pcnt_r <= 4'h0;
						ocnt_r <= 3'h0;
						fba_r <= 11'h000;
						rev_r <= rev;
						dw_r <= 1'b0;
						o_fcs_dis <= win_cfg[0];
						o_addr_filt_dis <= win_cfg[0];
						if (!win_cfg[0])
							state_r <= ST_PHR;
						else if (rlen_r == 11'h000)
							state_r <= ST_LISTEN;
						else begin
							rxlen_r <= rlen_r;
							edv_r <= i_energy;
							bcnt_r <= {rlen_r, 3'b000};
							o_frame_start_irq <= 1'b1;
							state_r <= ST_PSDU;
						end
					end else if (i_sym_vld) begin
						tcnt_r <= tcnt_r + 13'h0001;
						if (pto & (tcnt_r + 13'h0001 >= tlim))
							state_r <= ST_LISTEN;
						else if (!pto & (i_pre_corr <= pthr_r))
							state_r <= ST_LISTEN;
					end
				end
				ST_PHR: begin
					if (i_dbit_vld) begin
						phr_r <= phr_full;
						pcnt_r <= pcnt_r + 4'h1;
						ms_r <= ms_now;
						if (pcnt_r == `FSRX_PHR_LAST) begin
							edv_r <= i_energy;
							if (ms_now) begin
								// Other header fields are not meaningful here
								phr_st_r <= {phr_st_r[5], 5'h01};
								o_fcs_dis <= 1'b1;
								o_addr_filt_dis <= 1'b1;
								rxlen_r <= 11'h002;
								o_frame_start_irq <= 1'b1;
								o_rx_done <= 1'b1;
								state_r <= ST_LISTEN;
							end else if (phr_len == 11'h000) begin
								state_r <= ST_LISTEN;
							end else begin
								phr_st_r <= {phr_st_r[5], phr_full[11], phr_full[12],
									phr_full[13], phr_full[14], phr_full[15]};
								rxlen_r <= phr_len;
								dw_r <= phr_full[11];
								pn_r <= `FSRX_PN_SEED;
								rev_r <= 1'b0;
								ocnt_r <= 3'h0;
								bcnt_r <= {phr_len, 3'b000};
								o_frame_start_irq <= 1'b1;
								state_r <= ST_PSDU;
							end
						end
					end
				end
				ST_PSDU: begin
					if (i_dbit_vld) begin
						pn_r <= {pn_r[0] ^ pn_r[5], pn_r[8:1]};
						bcnt_r <= bcnt_r - 14'h0001;
						if (bcnt_r == 14'h0001) begin
							o_rx_done <= 1'b1;
							state_r <= ST_LISTEN;
						end
					end
				end
				default: state_r <= ST_LISTEN;
			endcase
			// Abort keeps the last status but drops any frame in flight
			if (!en)
				state_r <= ST_LISTEN;
		end
	end

endmodule

`default_nettype wire

// ==== tb/fsrx_demod_model.sv ====
/* Far transmitter as seen through the demodulator: soft symbols with a
   correlator value, then decoded info bits. Assumes one calling process. */
`timescale 1ns/10ps
`default_nettype none
module fsrx_demod_model (
	input  wire        i_clk,
	output logic       o_sym_vld = 1'b0,
	output logic [3:0] o_sym = 4'h0,
	output logic [7:0] o_pre_corr = 8'h00,
	output logic       o_dbit_vld = 1'b0,
	output logic       o_dbit = 1'b0
);
	// Off-strobe lines show the inverse, so a stale value never passes
	task automatic sym(input logic [3:0] s, input logic [7:0] c);
		@(posedge i_clk);
		o_sym_vld <= 1'b1;
		o_sym <= s;
		o_pre_corr <= c;
		@(posedge i_clk);
		o_sym_vld <= 1'b0;
		o_sym <= ~s;
		o_pre_corr <= ~c;
	endtask
	// Oldest symbol carries bit 15; a one is sent as +m, a zero as -m
	task automatic word_m(input logic [15:0] w, input logic [3:0] m);
		for (int i = 15; i >= 0; i--)
			sym(w[i] ? m : 4'h0 - m, 8'hFF);
		// Decoded bits only follow once the receiver has had time to sync
		repeat (2) @(posedge i_clk);
	endtask
	task automatic word(input logic [15:0] w);
		word_m(w, 4'h7);
	endtask
	// Flush history unlocked, then two preamble octets
	task automatic pre();
		repeat (16) sym(4'h0, 8'h00);
		repeat (16) sym(4'h0, 8'hFF);
	endtask
	task automatic bits(input logic [15:0] v, input int n, input logic lsb);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			o_dbit_vld <= 1'b1;
			o_dbit <= lsb ? v[i] : v[n-1-i];
			@(posedge i_clk);
			o_dbit_vld <= 1'b0;
			o_dbit <= ~o_dbit;
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/fsrx_sva.sv ====
/* Port checker for the FSK receive acquisition block.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module fsrx_sva (
	input wire        i_clk,
	input wire        i_rst_b,
	input wire        i_rd,
	input wire [7:0]  o_rdata,
	input wire        i_sym_vld,
	input wire [7:0]  i_pre_corr,
	input wire        o_freeze_status,
	input wire        o_raw_mode,
	input wire        o_fcs_dis,
	input wire        o_addr_filt_dis,
	input wire        o_frame_start_irq,
	input wire        o_rx_done,
	input wire        o_fb_we,
	input wire [10:0] o_fb_addr
);
	logic [10:0] fb_addr_r;
	always @(posedge i_clk) begin
		if (!i_rst_b)
			fb_addr_r <= 11'h000;
		else if (o_fb_we)
			fb_addr_r <= o_fb_addr + 11'h001;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// ==========================================================
	// Properties
	property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_lock_rise; $rose(o_freeze_status) |-> $past(i_sym_vld, 2) && $past(i_pre_corr, 2) != 8'h00; endproperty
	a_lock_rise: assert property (p_lock_rise) else $error("lock without symbol");
	property p_fs_lock; o_frame_start_irq |-> o_freeze_status; endproperty
	a_fs_lock: assert property (p_fs_lock) else $error("frame start outside lock");
	property p_fs_pulse; o_frame_start_irq |=> !o_frame_start_irq; endproperty
	a_fs_pulse: assert property (p_fs_pulse) else $error("frame start too long");
	property p_done_pulse; o_rx_done |=> !o_rx_done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too long");
	property p_raw_dis; o_frame_start_irq && o_raw_mode |-> o_fcs_dis && o_addr_filt_dis; endproperty
	a_raw_dis: assert property (p_raw_dis) else $error("raw frame filters on");
	property p_ms_dis; o_frame_start_irq && o_rx_done && !o_raw_mode ##0 1'b1 |-> o_fcs_dis ##0 o_addr_filt_dis; endproperty
	a_ms_dis: assert property (p_ms_dis) else $error("mode switch filters on");
	property p_fb_seq; o_fb_we |-> o_fb_addr == 11'h000 || o_fb_addr == fb_addr_r; endproperty
	a_fb_seq: assert property (p_fb_seq) else $error("buffer address skipped");
	c_raw: cover property (o_frame_start_irq && o_raw_mode);
	c_ms: cover property (o_frame_start_irq && o_rx_done);
	c_lock: cover property ($rose(o_freeze_status));
endmodule
bind fsrx_top fsrx_sva u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_sym_vld(i_sym_vld), .i_pre_corr(i_pre_corr), .o_freeze_status(o_freeze_status),
	.o_raw_mode(o_raw_mode), .o_fcs_dis(o_fcs_dis), .o_addr_filt_dis(o_addr_filt_dis),
	.o_frame_start_irq(o_frame_start_irq), .o_rx_done(o_rx_done), .o_fb_we(o_fb_we),
	.o_fb_addr(o_fb_addr));
`default_nettype wire

// ==== tb/test_fsk_rx_sync_header_parser.sv ====
/* Self-checking bench for the FSK receive acquisition block.
   Assumes the demodulator model drives the symbol and bit inputs. */
`timescale 1ns/10ps
`default_nettype none
module test_fsk_rx_sync_header_parser;
	logic        i_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [7:0]  i_wdata = 8'h00;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [7:0]  i_energy = 8'h00;
	logic        rd_d = 1'b0;
	logic [7:0]  exp_q[$];
	logic [7:0]  d0;
	logic [7:0]  d1;
	int          bad_count = 0;
	int          num_checks = 0;
	int          fs_cnt = 0;
	int          done_cnt = 0;
	int          seed = 32'h4a95;
	logic [7:0]  ra[8] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h07, 8'h09, 8'h10, 8'h20};
	logic [7:0]  rv[8] = '{8'h40, 8'h40, 8'h08, 8'h4E, 8'h90, 8'h7A, 8'h00, 8'h00};
	wire         sym_vld, dbit_vld, dbit, frz, raw, fec, fcs_d, afl_d, fs, done, we;
	wire [3:0]   sym;
	wire [7:0]   pre_corr, rdata, fb_wdata;
	wire [10:0]  fb_addr;
	always #5 i_clk = ~i_clk;
	fsrx_demod_model u_tx (.i_clk(i_clk), .o_sym_vld(sym_vld), .o_sym(sym),
		.o_pre_corr(pre_corr), .o_dbit_vld(dbit_vld), .o_dbit(dbit));
	fsrx_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_sym_vld(sym_vld), .i_sym(sym),
		.i_pre_corr(pre_corr), .i_dbit_vld(dbit_vld), .i_dbit(dbit), .i_energy(i_energy),
		.o_freeze_status(frz), .o_raw_mode(raw), .o_fec_en(fec), .o_fcs_dis(fcs_d),
		.o_addr_filt_dis(afl_d), .o_frame_start_irq(fs), .o_rx_done(done), .o_fb_we(we),
		.o_fb_addr(fb_addr), .o_fb_wdata(fb_wdata));
	// ==========================================================
	// Tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	// Bounded wait, so a missing event reports instead of hanging
	task automatic wait_cnt(input int n, input logic want_done);
		for (int i = 0; i < 400 && (want_done ? done_cnt : fs_cnt) < n; i++)
			@(posedge i_clk);
	endtask
	task automatic endt(input int n);
		repeat (4) @(posedge i_clk);
		$display("test %0d done", n);
	endtask
	task automatic finish_test();
		$display("checks=%0d bad=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// Monitor: results pop the oldest note
	always @(posedge i_clk) begin
		rd_d <= i_rd;
		if (rd_d)
			check(rdata, exp_q.pop_front());
		if (we)
			check(fb_wdata, exp_q.pop_front());
		if (fs)
			fs_cnt++;
		if (done)
			done_cnt++;
	end
	initial begin
		#200000;
		bad_count++;
		finish_test();
	end
	// ==========================================================
	// Scenarios
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		i_energy <= 8'($random(seed));
		for (int i = 0; i < 8; i++)
			rd(ra[i], rv[i]);
		endt(0);
		u_tx.sym(4'h0, 8'h40);
		rd(8'h10, 8'h00);
		u_tx.sym(4'h0, 8'h41);
		rd(8'h10, 8'h01);
		u_tx.sym(4'h0, 8'h40);
		rd(8'h10, 8'h00);
		endt(1);
		wr(8'h00, 8'h41);
		wr(8'h04, 8'h01);
		u_tx.sym(4'h0, 8'hFF);
		repeat (6) u_tx.sym(4'h0, 8'h00);
		rd(8'h10, 8'h01);
		repeat (2) u_tx.sym(4'h0, 8'h00);
		rd(8'h10, 8'h00);
		wr(8'h00, 8'h40);
		endt(2);
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		wr(8'h03, 8'h04);
		wr(8'h0A, 8'h02);
		u_tx.pre();
		u_tx.word(16'h7A0E);
		wait_cnt(1, 1'b0);
		check(fs_cnt, 1);
		check({raw, fec}, 2'b10);
		check({fcs_d, afl_d}, 2'b11);
		rd(8'h14, i_energy);
		exp_q.push_back(d0);
		exp_q.push_back(d1);
		u_tx.bits({d1, d0}, 16, 1'b1);
		wait_cnt(1, 1'b1);
		check(done_cnt, 1);
		endt(3);
		wr(8'h00, 8'h42);
		exp_q.push_back(8'h83);
		exp_q.push_back(8'hC4);
		u_tx.pre();
		u_tx.word(16'h904E);
		u_tx.bits(16'hC123, 16, 1'b0);
		wait_cnt(2, 1'b0);
		check(fs_cnt, 2);
		check({raw, fcs_d, afl_d}, 3'b011);
		rd(8'h11, 8'h01);
		rd(8'h12, 8'h02);
		endt(4);
		wr(8'h00, 8'h40);
		u_tx.pre();
		u_tx.word(16'h904E);
		u_tx.bits(16'h0000, 16, 1'b0);
		repeat (20) @(posedge i_clk);
		check(fs_cnt, 2);
		rd(8'h10, 8'h00);
		endt(5);
		wr(8'h08, 8'h4E);
		wr(8'h09, 8'h90);
		exp_q.push_back(d0);
		u_tx.pre();
		u_tx.word(16'h904E);
		u_tx.bits(16'h5001, 16, 1'b0);
		u_tx.bits({8'h00, d0}, 8, 1'b1);
		wait_cnt(3, 1'b1);
		check(fs_cnt, 3);
		check(done_cnt, 3);
		check({raw, fcs_d, afl_d}, 3'b000);
		rd(8'h11, 8'h0A);
		rd(8'h12, 8'h01);
		endt(6);
		wr(8'h00, 8'h5C);
		wr(8'h02, 8'h08);
		wr(8'h03, 8'h03);
		wr(8'h08, 8'h0E);
		wr(8'h09, 8'h7A);
		u_tx.pre();
		u_tx.word_m(16'h904E, 4'h1);
		u_tx.word_m(16'h7A0E, 4'h1);
		wait_cnt(4, 1'b0);
		check(fs_cnt, 4);
		check({raw, fec}, 2'b11);
		rd(8'h11, 8'h00);
		exp_q.push_back(d1);
		exp_q.push_back(d0);
		u_tx.bits({d1, d0}, 16, 1'b0);
		wait_cnt(4, 1'b1);
		check(done_cnt, 4);
		endt(7);
		finish_test();
	end
endmodule
`default_nettype wire
